// ===== pkg/mlt_pkg.sv
// package for the layer-2 address table: register map, fields, reset values, timing
// assumes a single 200 MHz clock and an apb master for management
//
// Overview of operation
// [RULE1] forward by destination address table lookup
// [RULE2] source address creates or refreshes dynamic entry
// [RULE3] silent dynamic entries removed after age interval
// [RULE4] age time in seconds, ranged, reset 300
// [RULE5] global switch suspends all aging
// [RULE6] auto mode learns unknown source at once
// [RULE7] learning off: no table change, still forward
// [RULE8] secure mode: only static sources pass
// [RULE9] owned learning mode ignores management writes
// [RULE10] at most 64 static entries, vid-keyed
// [RULE11] agent supplies vid, address, port mask
// [RULE12] table capacity 8192, ordered vid then address
// [RULE13] get-next returns exact or following entry
// [RULE14] get-first returns lowest vid and address
// [RULE15] read-back gives type, vid, address, ports
// [RULE16] flush removes all dynamic entries at once; a dynamic entry refreshed by learning in the flush cycle stays
// [RULE17] static entries survive aging and flush
// [RULE18] unknown destination floods vlan except ingress
package mlt_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_AGE = 8'h04;
  localparam logic [7:0] OFF_LEARN = 8'h08;
  localparam logic [7:0] OFF_KVID = 8'h0c;
  localparam logic [7:0] OFF_KMLO = 8'h10;
  localparam logic [7:0] OFF_KMHI = 8'h14;
  localparam logic [7:0] OFF_KPORTS = 8'h18;
  localparam logic [7:0] OFF_CMD = 8'h1c;
  localparam logic [7:0] OFF_RSTAT = 8'h20;
  localparam logic [7:0] OFF_RVID = 8'h24;
  localparam logic [7:0] OFF_RMLO = 8'h28;
  localparam logic [7:0] OFF_RMHI = 8'h2c;
  localparam logic [7:0] OFF_RPORTS = 8'h30;
  // ==========================================================
  // field positions
  localparam int CTRL_AGEDIS_BIT = 0;
  localparam int CTRL_FLUSH_BIT = 1;
  localparam int LRN_MODE_LSB = 8;
  localparam int LRN_OWNED_BIT = 10;
  localparam int RST_FOUND_BIT = 0;
  localparam int RST_STATIC_BIT = 1;
  localparam int RST_OK_BIT = 2;
  localparam int RST_SCNT_LSB = 8;
  // ==========================================================
  // learning modes and commands
  localparam logic [1:0] LM_AUTO = 2'h0;
  localparam logic [1:0] LM_OFF = 2'h1;
  localparam logic [1:0] LM_SECURE = 2'h2;
  localparam logic [2:0] CMD_ADD = 3'h1;
  localparam logic [2:0] CMD_DEL = 3'h2;
  localparam logic [2:0] CMD_FIRST = 3'h3;
  localparam logic [2:0] CMD_NEXT = 3'h4;
  // ==========================================================
  // reset values and timing
  localparam logic [23:0] AGE_DEF_S = 24'h00012c; // 300 s
  localparam logic [23:0] AGE_MIN_S = 24'h00000a; // 10 s
  localparam logic [23:0] AGE_MAX_S = 24'h989680; // 10000000 s
  localparam int SEC_NS = 1000000000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CYC_PER_SEC_DEF = SEC_NS / CLK_PERIOD_NS;
  localparam int VID_W = 12;
  localparam int MAC_W = 48;
  localparam int KEY_W = VID_W + MAC_W;
endpackage

// ===== pkg/mlt_search_if.sv
// carrier between the table and its ordered key search
// assumes the table drives keys and valid bits, the search answers combinationally
`timescale 1ns/100ps
`default_nettype none
interface mlt_search_if #(parameter int N = 8192, parameter int IW = 13);
  logic [59:0] start; // lowest acceptable key
  logic [59:0] key [N]; // vid then address per slot
  logic [N-1:0] valid; // slot occupied
  logic found; // some key at or above start
  logic [IW-1:0] idx; // slot holding the least such key
  modport req (output start, key, valid, input found, idx);
  modport srv (input start, key, valid, output found, idx);
endinterface
`default_nettype wire

// ===== rtl/mlt_age_timer.sv
// aging tick generator: one sweep pulse per programmed age interval
// assumes age_secs already lies within the legal range
`timescale 1ns/100ps
`default_nettype none
module mlt_age_timer import mlt_pkg::*; #(
  parameter int CYC_PER_SEC = CYC_PER_SEC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic age_dis,
  input wire logic [23:0] age_secs,
  output logic sweep
);
  logic [27:0] pre_q; // cycle prescaler
  logic [23:0] sec_q; // elapsed seconds
  wire sec_end = (pre_q == 28'(CYC_PER_SEC - 1));
  wire int_end = sec_end && (sec_q >= age_secs - 24'h000001);
  // ==========================================================
  // counters freeze while aging is suspended
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      sec_q <= '0;
    end else if (!age_dis) begin // [RULE5]
      pre_q <= sec_end ? 28'h0000000 : pre_q + 28'h0000001;
      if (int_end) sec_q <= '0; // [RULE3]
      else if (sec_end) sec_q <= sec_q + 24'h000001;
    end
  end
  assign sweep = int_end && !age_dis;
  no_sweep_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    age_dis |-> !sweep ##1 ($stable(pre_q) && $stable(sec_q)))
    else $error("aging ran while suspended");
endmodule // mlt_age_timer
`default_nettype wire

// ===== rtl/mlt_key_search.sv
// ordered search: least valid key not below a start key
// assumes keys are unique across slots
`timescale 1ns/100ps
`default_nettype none
module mlt_key_search #(
  parameter int N = 8192,
  parameter int IW = 13
) (
  mlt_search_if.srv s
);
  // ==========================================================
  // linear scan; big but single cycle, which keeps the command path simple
  always_comb begin
    logic [59:0] best;
    best = '1;
    s.found = 1'b0;
    s.idx = '0;
    for (int i = 0; i < N; i++) begin
      if (s.valid[i] && s.key[i] >= s.start && (!s.found || s.key[i] < best)) begin // [RULE13]
        s.found = 1'b1;
        best = s.key[i];
        s.idx = IW'(i);
      end
    end
  end
endmodule // mlt_key_search
`default_nettype wire

// ===== rtl/mlt_table.sv
// layer-2 address table: lookup, learning, aging, static entries, ordered read-back
// assumes ingress requests come from logic on pclk and management over apb
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module mlt_table import mlt_pkg::*; #(
  parameter int ENTRIES = 8192,
  parameter int STATICS = 64,
  parameter int PORTS = 24,
  parameter int PW = 5,
  parameter int CYC_PER_SEC = CYC_PER_SEC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ing_valid,
  input wire logic [PW-1:0] ing_port,
  input wire logic [11:0] ing_vid,
  input wire logic [47:0] dest_addr_field,
  input wire logic [47:0] source_addr_field,
  input wire logic [PORTS-1:0] ing_vlan_ports,
  input wire logic [PORTS-1:0] lrn_owned,
  output logic fwd_valid,
  output logic [PORTS-1:0] fwd_ports,
  output logic fwd_drop
);
  localparam int IW = $clog2(ENTRIES);
  localparam int CW = $clog2(STATICS + 1);

  // ==========================================================
  // table storage
  logic [ENTRIES-1:0] v_q; // slot valid
  logic [ENTRIES-1:0] st_q; // slot static
  logic [ENTRIES-1:0] hit_q; // seen since last sweep
  logic [11:0] vid_q [ENTRIES];
  logic [47:0] mac_q [ENTRIES];
  logic [PORTS-1:0] pm_q [ENTRIES];
  logic [CW-1:0] scnt_q; // static entries held
  mlt_search_if #(.N(ENTRIES), .IW(IW)) srch (); // carrier to the ordered search

  // ==========================================================
  // management state
  logic age_dis_q; // aging suspended
  logic [23:0] age_q; // age time in seconds
  logic [1:0] lm_q [PORTS]; // learning mode per port
  logic [PW-1:0] lsel_q; // port shown in learn register
  logic [11:0] kvid_q;
  logic [47:0] kmac_q;
  logic [PORTS-1:0] kpm_q;
  logic rfound_q, rstatic_q, rok_q;
  logic [11:0] rvid_q;
  logic [47:0] rmac_q;
  logic [PORTS-1:0] rpm_q;
  logic [31:0] prdata_q;
  logic fwd_valid_q, fwd_drop_q;
  logic [PORTS-1:0] fwd_ports_q;

  // ==========================================================
  // decoding helpers
  function automatic logic key_eq(input logic [11:0] va, input logic [47:0] ma,
                                  input logic [11:0] vb, input logic [47:0] mb);
    key_eq = (va == vb) && (ma == mb);
  endfunction

  // lowest set bit with a found flag on top
  function automatic logic [IW:0] first_set(input logic [ENTRIES-1:0] vec);
    logic [IW:0] r;
    r = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (vec[i]) r = {1'b1, IW'(i)};
    end
    return r;
  endfunction

  // ==========================================================
  // parallel match against every slot
  wire [ENTRIES-1:0] src_m, dst_m, key_m;
  for (genvar g = 0; g < ENTRIES; g++) begin : g_match
    assign src_m[g] = v_q[g] && key_eq(vid_q[g], mac_q[g], ing_vid, source_addr_field);
    assign dst_m[g] = v_q[g] && key_eq(vid_q[g], mac_q[g], ing_vid, dest_addr_field);
    assign key_m[g] = v_q[g] && key_eq(vid_q[g], mac_q[g], kvid_q, kmac_q);
  end
  wire [IW:0] src_f = first_set(src_m);
  wire [IW:0] dst_f = first_set(dst_m);
  wire [IW:0] key_f = first_set(key_m);
  wire [IW:0] free_f = first_set(~v_q);
  wire [IW-1:0] src_i = src_f[IW-1:0];
  wire [IW-1:0] dst_i = dst_f[IW-1:0];
  wire [IW-1:0] key_i = key_f[IW-1:0];
  wire [IW-1:0] free_i = free_f[IW-1:0];

  // ==========================================================
  // apb decode; writes land in the access phase
  wire wr = psel && penable && pwrite;
  wire rd_setup = psel && !penable && !pwrite;
  wire known = paddr inside {OFF_CTRL, OFF_AGE, OFF_LEARN, OFF_KVID, OFF_KMLO,
                             OFF_KMHI, OFF_KPORTS, OFF_CMD, OFF_RSTAT, OFF_RVID,
                             OFF_RMLO, OFF_RMHI, OFF_RPORTS};
  wire cmd_wr = wr && paddr == OFF_CMD;
  wire [2:0] cmd = pwdata[2:0];
  wire flush = wr && paddr == OFF_CTRL && pwdata[CTRL_FLUSH_BIT];
  wire lrn_wr = wr && paddr == OFF_LEARN;
  wire [PW-1:0] lrn_port = pwdata[PW-1:0];
  wire [1:0] lrn_cur = lm_q[lrn_port]; // mode held before a learn write
  wire room = scnt_q < CW'(STATICS);
  // add refuses once the static budget is used, unless the key is already static
  wire add_ok = cmd_wr && cmd == CMD_ADD &&
                (key_f[IW] ? (st_q[key_i] || room) : (free_f[IW] && room)); // [RULE10]
  wire [IW-1:0] add_i = key_f[IW] ? key_i : free_i;
  wire add_new_st = add_ok && !(key_f[IW] && st_q[key_i]);
  wire del_ok = cmd_wr && cmd == CMD_DEL && key_f[IW];
  wire del_st = del_ok && st_q[key_i];
  wire srch_cmd = cmd_wr && (cmd == CMD_FIRST || cmd == CMD_NEXT);
  wire cmd_ok = add_ok || del_ok || (srch_cmd && srch.found);
  wire [23:0] age_wv = pwdata[23:0] < AGE_MIN_S ? AGE_MIN_S :
                       pwdata[23:0] > AGE_MAX_S ? AGE_MAX_S : pwdata[23:0];

  // ==========================================================
  // ingress decisions
  wire [1:0] lmode = lm_q[ing_port];
  wire [PORTS-1:0] in_bit = PORTS'(1) << ing_port;
  wire src_static = src_f[IW] && st_q[src_i];
  wire sec_drop = ing_valid && lmode == LM_SECURE && !src_static; // [RULE8]
  // learning yields to a management command in the same cycle
  wire auto_ok = ing_valid && lmode == LM_AUTO && !cmd_wr;
  wire learn_new = auto_ok && !src_f[IW] && free_f[IW]; // [RULE6]
  wire learn_upd = auto_ok && src_f[IW] && !st_q[src_i]; // [RULE2]
  wire [PORTS-1:0] fwd_d = dst_f[IW] ? pm_q[dst_i] & ~in_bit : // [RULE1]
                           ing_vlan_ports & ~in_bit; // [RULE18]
  wire sweep;

  // ==========================================================
  // aging interval timer
  mlt_age_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_age (
    .pclk(pclk),
    .presetn(presetn),
    .age_dis(age_dis_q),
    .age_secs(age_q),
    .sweep(sweep)
  );

  // ==========================================================
  // ordered search for read-back
  assign srch.start = cmd == CMD_FIRST ? 60'h000000000000000 : {kvid_q, kmac_q}; // [RULE14]
  assign srch.valid = v_q;
  for (genvar g = 0; g < ENTRIES; g++) begin : g_key
    assign srch.key[g] = {vid_q[g], mac_q[g]}; // [RULE12]
  end
  mlt_key_search #(.N(ENTRIES), .IW(IW)) u_srch (
    .s(srch)
  );

  // ==========================================================
  // slot updates; later statements win, add and delete commands last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v_q <= '0;
      st_q <= '0;
      hit_q <= '0;
      for (int i = 0; i < ENTRIES; i++) begin
        vid_q[i] <= '0;
        mac_q[i] <= '0;
        pm_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < ENTRIES; i++) begin
        // two-pass aging: a slot unseen for a whole interval goes
        if (sweep && v_q[i] && !st_q[i]) begin // [RULE3] [RULE17]
          if (hit_q[i]) hit_q[i] <= 1'b0;
          else v_q[i] <= 1'b0;
        end
        if (flush && !st_q[i]) v_q[i] <= 1'b0; // [RULE16] [RULE17]
      end
      if (learn_upd) begin // [RULE2]
        // a refresh in the sweep cycle keeps the entry alive
        v_q[src_i] <= 1'b1;
        hit_q[src_i] <= 1'b1;
        pm_q[src_i] <= in_bit;
      end
      if (learn_new) begin // [RULE6]
        v_q[free_i] <= 1'b1;
        st_q[free_i] <= 1'b0;
        hit_q[free_i] <= 1'b1;
        vid_q[free_i] <= ing_vid;
        mac_q[free_i] <= source_addr_field;
        pm_q[free_i] <= in_bit;
      end
      if (add_ok) begin // [RULE10]
        v_q[add_i] <= 1'b1;
        st_q[add_i] <= 1'b1;
        vid_q[add_i] <= kvid_q;
        mac_q[add_i] <= kmac_q;
        pm_q[add_i] <= kpm_q;
      end
      if (del_ok) begin
        v_q[key_i] <= 1'b0;
        st_q[key_i] <= 1'b0;
      end
    end
  end

  // static budget follows adds and deletes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) scnt_q <= '0;
    else if (add_new_st) scnt_q <= scnt_q + CW'(1); // [RULE10]
    else if (del_st) scnt_q <= scnt_q - CW'(1);
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_dis_q <= 1'b0;
      age_q <= AGE_DEF_S; // [RULE4]
      lsel_q <= '0;
      kvid_q <= '0;
      kmac_q <= '0;
      kpm_q <= '0;
      for (int p = 0; p < PORTS; p++) lm_q[p] <= LM_AUTO;
    end else if (wr) begin
      if (paddr == OFF_CTRL) age_dis_q <= pwdata[CTRL_AGEDIS_BIT]; // [RULE5]
      if (paddr == OFF_AGE) age_q <= age_wv; // [RULE4]
      if (lrn_wr && lrn_port < PW'(PORTS)) begin
        lsel_q <= lrn_port;
        // another function owning the port freezes its mode
        if (!lrn_owned[lrn_port]) lm_q[lrn_port] <= pwdata[LRN_MODE_LSB +: 2]; // [RULE9]
      end
      if (paddr == OFF_KVID) kvid_q <= pwdata[11:0]; // [RULE11]
      if (paddr == OFF_KMLO) kmac_q[31:0] <= pwdata;
      if (paddr == OFF_KMHI) kmac_q[47:32] <= pwdata[15:0];
      if (paddr == OFF_KPORTS) kpm_q <= pwdata[PORTS-1:0];
    end
  end

  // ==========================================================
  // command results held for read-back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rfound_q <= 1'b0;
      rstatic_q <= 1'b0;
      rok_q <= 1'b0;
      rvid_q <= '0;
      rmac_q <= '0;
      rpm_q <= '0;
    end else if (cmd_wr) begin
      rok_q <= cmd_ok;
      if (srch_cmd) begin // [RULE13] [RULE15]
        rfound_q <= srch.found;
        rstatic_q <= srch.found && st_q[srch.idx];
        rvid_q <= srch.found ? vid_q[srch.idx] : 12'h000;
        rmac_q <= srch.found ? mac_q[srch.idx] : 48'h000000000000;
        rpm_q <= srch.found ? pm_q[srch.idx] : '0;
      end
    end
  end

  // ==========================================================
  // read mux, captured in the setup phase
  wire [31:0] lrn_rd = 32'({lrn_owned[lsel_q], lm_q[lsel_q]}) << LRN_MODE_LSB;
  wire [31:0] st_rd = (32'(scnt_q) << RST_SCNT_LSB) | (32'(rok_q) << RST_OK_BIT) |
                      (32'(rstatic_q) << RST_STATIC_BIT) | (32'(rfound_q) << RST_FOUND_BIT);
  wire [31:0] rd_mux =
    paddr == OFF_CTRL ? 32'(age_dis_q) << CTRL_AGEDIS_BIT :
    paddr == OFF_AGE ? 32'(age_q) :
    paddr == OFF_LEARN ? (lrn_rd | 32'(lsel_q)) :
    paddr == OFF_KVID ? 32'(kvid_q) :
    paddr == OFF_KMLO ? kmac_q[31:0] :
    paddr == OFF_KMHI ? 32'(kmac_q[47:32]) :
    paddr == OFF_KPORTS ? 32'(kpm_q) :
    paddr == OFF_RSTAT ? st_rd :
    paddr == OFF_RVID ? 32'(rvid_q) :
    paddr == OFF_RMLO ? rmac_q[31:0] :
    paddr == OFF_RMHI ? 32'(rmac_q[47:32]) :
    paddr == OFF_RPORTS ? 32'(rpm_q) : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= '0;
    else if (rd_setup) prdata_q <= rd_mux;
  end

  // ==========================================================
  // forwarding answer one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_valid_q <= 1'b0;
      fwd_drop_q <= 1'b0;
      fwd_ports_q <= '0;
    end else begin
      fwd_valid_q <= ing_valid;
      fwd_drop_q <= sec_drop;
      fwd_ports_q <= (ing_valid && !sec_drop) ? fwd_d : '0; // [RULE7]
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;
  assign fwd_valid = fwd_valid_q;
  assign fwd_drop = fwd_drop_q;
  assign fwd_ports = fwd_ports_q;

  // ==========================================================
  // checks
  sequence s_req;
    ing_valid && !cmd_wr && !flush && !sweep;
  endsequence
  fwd_lat_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    ing_valid |=> fwd_valid) else $error("no forward answer");
  flood_miss_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
    (ing_valid && !dst_f[IW] && !sec_drop) |=>
    fwd_ports == ($past(ing_vlan_ports) & ~$past(in_bit)))
    else $error("miss not flooded");
  learn_new_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    learn_new |=> v_q[$past(free_i)] && !st_q[$past(free_i)]) else $error("no learn");
  off_nolearn_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    (s_req and lmode == LM_OFF) |=> v_q == $past(v_q)) else $error("learned while off");
  secure_drop_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    (ing_valid && lmode == LM_SECURE && !src_static) |=> fwd_drop && fwd_ports == '0)
    else $error("secure port passed frame");
  owned_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    (lrn_wr && lrn_port < PW'(PORTS) && lrn_owned[lrn_port]) |=>
    lm_q[$past(lrn_port)] == $past(lrn_cur)) else $error("owned mode changed");
  flush_dyn_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
    (flush && !ing_valid) |=> (v_q & ~st_q) == '0) else $error("flush left dynamic");
  static_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    ((flush || sweep) && !cmd_wr) |=> (v_q & st_q) == $past(v_q & st_q))
    else $error("static entry lost");
  static_cap_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    scnt_q <= CW'(STATICS)) else $error("static budget exceeded");
endmodule // mlt_table
`default_nettype wire

// ===== test/mlt_ing_model.sv
// partner model: switch ingress pipeline feeding the address table
// assumes the table answers one cycle after each frame it takes
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// ingress pipeline model
module mlt_ing_model (
  input wire logic pclk,
  output logic ing_valid,
  output logic [4:0] ing_port,
  output logic [11:0] ing_vid,
  output logic [47:0] dest_addr_field,
  output logic [47:0] source_addr_field,
  output logic [23:0] ing_vlan_ports,
  input wire logic fwd_valid,
  input wire logic [23:0] fwd_ports,
  input wire logic fwd_drop
);
  // idle at time zero, no frame offered
  initial begin
    ing_valid = 1'b0;
    ing_port = 5'h00;
    ing_vid = 12'h000;
    dest_addr_field = 48'h0;
    source_addr_field = 48'h0;
    ing_vlan_ports = 24'h0;
  end
  // one frame; fields are inverted once released so stale values never match
  task automatic frame(input logic [4:0] p, input logic [11:0] v, input logic [47:0] d,
    input logic [47:0] s, output logic ok, output logic [23:0] pr, output logic dr);
    @(posedge pclk);
    ing_valid <= 1'b1;
    ing_port <= p;
    ing_vid <= v;
    dest_addr_field <= d;
    source_addr_field <= s;
    ing_vlan_ports <= 24'hffffff;
    @(posedge pclk);
    ing_valid <= 1'b0;
    ing_port <= ~p;
    ing_vid <= ~v;
    dest_addr_field <= ~d;
    source_addr_field <= ~s;
    ing_vlan_ports <= 24'h0;
    #1;
    ok = fwd_valid;
    pr = fwd_ports;
    dr = fwd_drop;
  endtask
endmodule // mlt_ing_model
`default_nettype wire

// ===== test/mlt_table_tb.sv
// testbench for the address table: apb tasks, ingress model, sequential tests
// assumes the package, search interface and design modules are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) chk(n, 64'(e), 64'(g))
// ==========================================
// bench top
module mlt_table_tb import mlt_pkg::*; ();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ok, drop;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] lrn_owned, prt, vp, fp;
  logic [4:0] ip;
  logic [11:0] iv;
  logic [47:0] da, sa;
  logic iva, fva, fdr;
  int errors, num_checks;
  // short count makes one second ten cycles, so aging fits the run
  mlt_table #(.ENTRIES(16), .CYC_PER_SEC(10)) mlt_table_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ing_valid(iva), .ing_port(ip),
    .ing_vid(iv), .dest_addr_field(da), .source_addr_field(sa), .ing_vlan_ports(vp),
    .lrn_owned(lrn_owned), .fwd_valid(fva), .fwd_ports(fp), .fwd_drop(fdr));
  mlt_ing_model mlt_ing_model_i (.pclk(pclk), .ing_valid(iva), .ing_port(ip), .ing_vid(iv),
    .dest_addr_field(da), .source_addr_field(sa), .ing_vlan_ports(vp), .fwd_valid(fva),
    .fwd_ports(fp), .fwd_drop(fdr));
  // 200 mhz clock
  always #2.5 pclk = ~pclk;
  // ==========================================
  // helpers
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // key and mask always given together with the command
  task automatic cmd(input logic [2:0] op, input logic [11:0] v, input logic [47:0] m,
    input logic [23:0] p);
    wr(OFF_KVID, {20'h0, v});
    wr(OFF_KMLO, m[31:0]);
    wr(OFF_KMHI, {16'h0, m[47:32]});
    wr(OFF_KPORTS, {8'h0, p});
    wr(OFF_CMD, {29'h0, op});
  endtask
  // read back the result registers of the last lookup
  task automatic ent(input logic f, input logic s, input logic [11:0] v, input logic [47:0] m,
    input logic [23:0] p);
    logic [47:0] g;
    rdr(OFF_RSTAT);
    `CHK("found", f, rd[RST_FOUND_BIT]);
    `CHK("static", s, rd[RST_STATIC_BIT]);
    rdr(OFF_RVID);
    `CHK("vid", v, rd[11:0]);
    rdr(OFF_RMLO);
    g[31:0] = rd;
    rdr(OFF_RMHI);
    g[47:32] = rd[15:0];
    `CHK("addr", m, g);
    rdr(OFF_RPORTS);
    `CHK("ports", p, rd[23:0]);
  endtask
  task automatic fr(input logic [4:0] p, input logic [11:0] v, input logic [47:0] d,
    input logic [47:0] s);
    mlt_ing_model_i.frame(p, v, d, s, ok, prt, drop);
    `CHK("fwd valid", 1'b1, ok);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // hang guard, far beyond the fewer than a thousand cycles the tests need
  initial begin
    #100us;
    errors++;
    $display("watchdog expired");
    complete_run();
  end
  // ==========================================
  // test sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lrn_owned = 24'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdr(OFF_AGE);
    `CHK("age reset", 24'h00012c, rd[23:0]);
    rdr(8'h3c);
    `CHK("unmapped err", 1'b1, er);
    $display("test reset done");
    fr(5'h03, 12'h005, 48'h11, 48'h0a);
    `CHK("miss flood", 24'hfffff7, prt);
    fr(5'h07, 12'h005, 48'h0a, 48'h0b);
    `CHK("hit learned", 24'h000008, prt);
    $display("test learn done");
    cmd(CMD_ADD, 12'h002, 48'h0c, 24'h000041);
    rdr(OFF_RSTAT);
    `CHK("add ok", 8'h03, {rd[14:8], rd[RST_OK_BIT]});
    cmd(CMD_FIRST, 12'h0, 48'h0, 24'h0);
    ent(1'b1, 1'b1, 12'h002, 48'h0c, 24'h000041);
    cmd(CMD_NEXT, 12'h002, 48'h0d, 24'h0);
    ent(1'b1, 1'b0, 12'h005, 48'h0a, 24'h000008);
    cmd(CMD_NEXT, 12'h005, 48'h0b, 24'h0);
    ent(1'b1, 1'b0, 12'h005, 48'h0b, 24'h000080);
    cmd(CMD_NEXT, 12'h005, 48'h0c, 24'h0);
    ent(1'b0, 1'b0, 12'h000, 48'h0, 24'h0);
    $display("test readback done");
    wr(OFF_CTRL, 32'h2);
    cmd(CMD_FIRST, 12'h0, 48'h0, 24'h0);
    ent(1'b1, 1'b1, 12'h002, 48'h0c, 24'h000041);
    fr(5'h03, 12'h005, 48'h0a, 48'h11);
    `CHK("flushed flood", 24'hfffff7, prt);
    $display("test flush done");
    wr(OFF_LEARN, 32'h104);
    fr(5'h04, 12'h005, 48'h11, 48'h0d);
    `CHK("off forwards", 1'b0, drop);
    fr(5'h04, 12'h005, 48'h0d, 48'h11);
    `CHK("off no learn", 24'hffffef, prt);
    wr(OFF_LEARN, 32'h206);
    fr(5'h06, 12'h002, 48'h11, 48'h10);
    `CHK("secure drop", 25'h1000000, {drop, prt});
    fr(5'h06, 12'h002, 48'h11, 48'h0c);
    `CHK("secure pass", 25'h0ffffbf, {drop, prt});
    @(posedge pclk);
    lrn_owned <= 24'h000020;
    wr(OFF_LEARN, 32'h105);
    fr(5'h05, 12'h005, 48'h11, 48'h0e);
    fr(5'h04, 12'h005, 48'h0e, 48'h11);
    `CHK("owned kept", 24'h000020, prt);
    $display("test modes done");
    wr(OFF_AGE, 32'h5);
    rdr(OFF_AGE);
    `CHK("age clamp", 24'h00000a, rd[23:0]);
    wr(OFF_CTRL, 32'h1);
    fr(5'h05, 12'h005, 48'h11, 48'h0f);
    repeat (300) @(posedge pclk);
    fr(5'h04, 12'h005, 48'h0f, 48'h11);
    `CHK("aging off", 24'h000020, prt);
    wr(OFF_CTRL, 32'h0);
    repeat (230) @(posedge pclk);
    fr(5'h04, 12'h005, 48'h0f, 48'h11);
    `CHK("aged out", 24'hffffef, prt);
    $display("test aging done");
    // explicit delete is the only way a static entry goes
    cmd(CMD_DEL, 12'h002, 48'h0c, 24'h0);
    rdr(OFF_RSTAT);
    `CHK("del ok", 8'h01, {rd[14:8], rd[RST_OK_BIT]});
    fr(5'h06, 12'h002, 48'h11, 48'h0c);
    `CHK("deleted drops", 25'h1000000, {drop, prt});
    $display("test delete done");
    complete_run();
  end
endmodule // mlt_table_tb
`default_nettype wire
